//--- rtc_ctl_pkg.sv
/*
 * Constants for the clock control block: register offsets, field positions,
 * reset values and timing counts. Assumes a 20 MHz system clock.
 */
package rtc_ctl_pkg;
    localparam int          ADDR_W         = 15;
    localparam int          DATA_W         = 8;
    localparam logic [14:0] FLAGS_CTRL_OFS = 15'h7ff0;
    localparam logic [14:0] USER_BYTE_OFS  = 15'h7ff1;
    localparam logic [14:0] ALARM_SEC_OFS  = 15'h7ff2;
    localparam logic [14:0] TIME_LO_OFS    = 15'h7ff9;
    localparam logic [14:0] TIME_HI_OFS    = 15'h7fff;
    localparam int          TIME_REGS      = 7;
    localparam int          TIME_SEC_IDX   = 0;
    localparam int          TIME_YEAR_IDX  = 6;
    // Flags/control bit positions, then the alarm-seconds skip bit
    localparam int          BIT_WDOG       = 7;
    localparam int          BIT_ALARM      = 6;
    localparam int          BIT_SUPPLY     = 5;
    localparam int          BIT_CENTURY    = 4;
    localparam int          BIT_TEST       = 3;
    localparam int          BIT_TUNE       = 2;
    localparam int          BIT_FREEZE     = 1;
    localparam int          BIT_SNAP       = 0;
    localparam int          BIT_SKIP       = 7;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  USER_RST       = 8'h00;
    localparam logic [7:0]  ALARM_SEC_RST  = 8'h00;
    localparam logic [7:0]  YEAR_WRAP      = 8'h99;
    localparam logic [7:0]  SEC_MASK       = 8'h7f;
    // 512 Hz square wave: toggle every half period
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          TUNE_HZ        = 512;
    localparam int          TUNE_HALF_CYC  = CLK_HZ / (2 * TUNE_HZ);
endpackage

//--- rtc_reg_mem.sv
/*
 * Small register memory for the seven host-visible time bytes.
 * Assumes one write port and a separate read port, one write per cycle; read data registered.
 */
`timescale 1ns/100ps
module rtc_reg_mem #(
    parameter int DEPTH = 7,
    parameter int AW    = 3
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_r[raddr_i];
    end
endmodule

//--- rtc_flags_ctl.sv
/*
 * Clock flags/control, user byte and alarm-seconds registers, with the
 * freeze-and-load and snapshot handshakes to the timekeeping counters.
 * Assumes host strobes synchronous to clk_i, one access per strobe pulse,
 * and counters outside that report their update and rollover events.
 */
`timescale 1ns/100ps
module rtc_flags_ctl
    import rtc_ctl_pkg::*;
#(
    parameter int HALF_CYC = TUNE_HALF_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    input  wire logic                        rd_i,
    input  wire logic                        wr_i,
    input  wire logic [rtc_ctl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [rtc_ctl_pkg::DATA_W-1:0] wdata_i,
    output logic      [rtc_ctl_pkg::DATA_W-1:0] rdata_o,
    output logic                             rvalid_o,
    input  wire logic                        supply_low_i,
    input  wire logic                        year_wrap_i,
    input  wire logic                        alarm_hit_i,
    input  wire logic                        wdog_expired_i,
    input  wire logic                        irq_req_i,
    input  wire logic                        update_busy_i,
    input  wire logic [7:0]                  count_sec_i,
    input  wire logic [7:0]                  count_byte_i,
    output logic      [2:0]                  count_idx_o,
    input  wire logic [7:0]                  count_year_i,
    output logic                             freeze_o,
    output logic                             load_o,
    output logic      [7:0]                  load_data_o,
    output logic                             tune_o,
    output logic                             test_mode_o,
    output logic                             seconds_match_o,
    output logic                             irq_o,
    output logic                             tune_wave_o
);
    import rtc_ctl_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_UPD, CAPTURE, LOAD} seq_t;

    function automatic logic is_time(input logic [ADDR_W-1:0] a);
        return (a >= TIME_LO_OFS) && (a <= TIME_HI_OFS);
    endfunction

    logic [7:0]  ctrl_r;
    logic [7:0]  user_r;
    logic [7:0]  alarm_sec_r;
    logic        wdog_r, alarm_r, supply_r, century_r;
    logic [2:0]  idx_r;
    logic        rd_pend_r;
    logic [ADDR_W-1:0] raddr_r;
    logic [7:0]  dir_rdata_r;
    logic [$clog2(HALF_CYC+1)-1:0] tune_cnt_r;
    logic        tune_wave_r;
    seq_t        state_r, state_nxt;

    wire sel_ctrl  = addr_i == FLAGS_CTRL_OFS;
    wire sel_user  = addr_i == USER_BYTE_OFS;
    wire sel_alarm = addr_i == ALARM_SEC_OFS;
    wire sel_time  = is_time(addr_i);
    wire rd_ctrl   = rd_i && sel_ctrl;
    wire wr_ctrl   = wr_i && sel_ctrl;
    wire [2:0] host_idx = 3'(addr_i - TIME_LO_OFS);
    wire [7:0] ctrl_nxt = wr_ctrl ? wdata_i : ctrl_r;
    // No capture while frozen, host-written values would be lost
    wire snap_rise = wr_ctrl && wdata_i[BIT_SNAP] && !ctrl_r[BIT_SNAP]
                     && !ctrl_nxt[BIT_FREEZE];
    wire freeze_fall = wr_ctrl && !wdata_i[BIT_FREEZE] && ctrl_r[BIT_FREEZE];

    // Time memory: host writes and snapshot copies share the write port; loads share the read port with host reads
    wire       copying  = state_r == CAPTURE;
    wire       mem_we   = copying || (wr_i && sel_time);
    wire [2:0] mem_widx = copying ? idx_r : host_idx;
    wire [7:0] mem_wdat = copying ? count_byte_i : wdata_i;
    wire [2:0] mem_ridx = (state_r == LOAD) ? idx_r : host_idx;
    wire [7:0] mem_rdata;

    rtc_reg_mem #(.DEPTH(TIME_REGS), .AW(3)) u_time_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_widx),
        .wdata_i (mem_wdat),
        .raddr_i (mem_ridx),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IDLE: begin
                if (freeze_fall) begin
                    state_nxt = LOAD;
                end else if (snap_rise) begin
                    state_nxt = update_busy_i ? WAIT_UPD : CAPTURE;
                end
            end
            WAIT_UPD: begin
                if (!update_busy_i) begin
                    state_nxt = CAPTURE;
                end
            end
            CAPTURE: begin
                if (idx_r == 3'(TIME_REGS - 1)) begin
                    state_nxt = IDLE;
                end
            end
            LOAD: begin
                if (idx_r == 3'(TIME_REGS)) begin
                    state_nxt = IDLE;
                end
            end
            default: state_nxt = IDLE;
        endcase
    end

    wire [2:0] idx_nxt = (state_r == state_nxt) ? idx_r + 3'h1 : 3'h0;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_r <= IDLE;
            idx_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // Loads lag the memory read by one cycle
    // Capture index leads, so the counter byte matches idx_r when written
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            load_o      <= 1'b0;
            load_data_o <= 8'h00;
            count_idx_o <= 3'h0;
        end else begin
            load_o      <= (state_r == LOAD) && (idx_r != 3'h0);
            load_data_o <= mem_rdata;
            count_idx_o <= (state_r == LOAD) ? idx_r - 3'h1 : idx_nxt;
        end
    end

    // Supply-fail sticky, set beats read clear
    // Century sticky, set beats read clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            supply_r  <= 1'b0;
            century_r <= 1'b0;
            wdog_r    <= 1'b0;
            alarm_r   <= 1'b0;
        end else begin
            supply_r  <= supply_low_i || (supply_r && !rd_ctrl);
            century_r <= year_wrap_i || (century_r && !rd_ctrl);
            wdog_r    <= wdog_expired_i || (wdog_r && !rd_ctrl);
            alarm_r   <= alarm_hit_i || (alarm_r && !rd_ctrl);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_r      <= CTRL_RST;
            user_r      <= USER_RST;
            alarm_sec_r <= ALARM_SEC_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (wr_i && sel_user) begin
                user_r <= wdata_i;
            end
            if (wr_i && sel_alarm) begin
                alarm_sec_r <= wdata_i;
            end
        end
    end

    // Flags read back as sticky bits, cleared by that read; direct registers read in two cycles
    wire [7:0] ctrl_view = {wdog_r, alarm_r, supply_r, century_r, ctrl_r[3:0]};
    wire [7:0] dir_rdata = sel_ctrl  ? ctrl_view :
                           sel_user  ? user_r :
                           sel_alarm ? alarm_sec_r : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_pend_r   <= 1'b0;
            raddr_r     <= '0;
            dir_rdata_r <= 8'h00;
            rvalid_o    <= 1'b0;
        end else begin
            rd_pend_r   <= rd_i;
            raddr_r     <= addr_i;
            dir_rdata_r <= dir_rdata;
            rvalid_o    <= rd_pend_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_pend_r) begin
            rdata_o <= is_time(raddr_r) ? mem_rdata : dir_rdata_r;
        end
    end

    wire sec_equal = (alarm_sec_r & SEC_MASK) == (count_sec_i & SEC_MASK);
    assign seconds_match_o = alarm_sec_r[BIT_SKIP] || sec_equal;

    assign freeze_o    = ctrl_r[BIT_FREEZE];
    // Test bit only passed through; host keeps it zero
    assign test_mode_o = ctrl_r[BIT_TEST];
    assign tune_o      = ctrl_r[BIT_TUNE];

    assign irq_o       = irq_req_i && !ctrl_r[BIT_TUNE];
    assign tune_wave_o = tune_wave_r;

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !ctrl_r[BIT_TUNE]) begin
            tune_cnt_r  <= '0;
            tune_wave_r <= 1'b0;
        end else if (tune_cnt_r == ($bits(tune_cnt_r))'(HALF_CYC - 1)) begin
            tune_cnt_r  <= '0;
            tune_wave_r <= !tune_wave_r;
        end else begin
            tune_cnt_r <= tune_cnt_r + 1'b1;
        end
    end

    wire unused_ok = ^{count_year_i};
endmodule

//--- rtc_counter_model.sv
/* Timekeeping counter model beside rtc_flags_ctl. Assumes idx from count_idx_o. */
`timescale 1ns/100ps
module rtc_counter_model (
    input  wire logic       clk_i,
    input  wire logic [2:0] idx_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_data_i,
    output logic      [7:0] byte_o
);
    logic [7:0] cnt [7];
    initial for (int i = 0; i < 7; i++) cnt[i] = 8'h20 + 8'(i);
    always @(posedge clk_i) if (load_i) cnt[idx_i] <= load_data_i;
    // Out of range index gives the inverted byte 6, never a stale byte
    assign byte_o = (idx_i < 3'h7) ? cnt[idx_i] : ~cnt[6];
endmodule

//--- rtc_flags_ctl_assertions.sv
/* Port checker for rtc_flags_ctl. Assumes clk_i domain, rstn_i sync low. */
`timescale 1ns/100ps
module rtc_flags_ctl_chk
    import rtc_ctl_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        rd_i,
    input wire logic        wr_i,
    input wire logic [14:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        rvalid_o,
    input wire logic        irq_req_i,
    input wire logic        irq_o,
    input wire logic        freeze_o,
    input wire logic        load_o,
    input wire logic [2:0]  count_idx_o,
    input wire logic        tune_o,
    input wire logic        tune_wave_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire ctl_wr = wr_i && addr_i == FLAGS_CTRL_OFS;
    property p_read_answer; rd_i |-> ##2 rvalid_o; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_freeze_set; ctl_wr && wdata_i[BIT_FREEZE] |-> ##[1:2] freeze_o; endproperty
    a_freeze_set: assert property (p_freeze_set) else $error("freeze not set");
    property p_freeze_hold; freeze_o && !ctl_wr |=> freeze_o; endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("freeze dropped");
    property p_frozen_no_load; freeze_o |-> !load_o; endproperty
    a_frozen_no_load: assert property (p_frozen_no_load) else $error("load while frozen");
    property p_load_start; $fell(freeze_o) |-> ##[1:3] load_o; endproperty
    a_load_start: assert property (p_load_start) else $error("no load after unfreeze");
    property p_load_run; load_o && count_idx_o == 3'h0 |-> load_o [*7]; endproperty
    a_load_run: assert property (p_load_run) else $error("load run short");
    property p_irq_mask; tune_o |-> !irq_o; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq in tuning mode");
    property p_irq_pass; !tune_o |-> irq_o == irq_req_i; endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq not passed");
    property p_wave_idle; !tune_o && !$past(tune_o) |-> !tune_wave_o; endproperty
    a_wave_idle: assert property (p_wave_idle) else $error("wave outside tuning");
endmodule
bind rtc_flags_ctl rtc_flags_ctl_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i),
    .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rvalid_o(rvalid_o),
    .irq_req_i(irq_req_i), .irq_o(irq_o), .freeze_o(freeze_o), .load_o(load_o),
    .count_idx_o(count_idx_o), .tune_o(tune_o), .tune_wave_o(tune_wave_o));

//--- rtc_flags_ctl_tb.sv
/* Testbench for rtc_flags_ctl. Assumes the counter model and bound checker. */
`timescale 1ns/100ps
module rtc_flags_ctl_tb;
    import rtc_ctl_pkg::*;
    logic        clk_i, rstn_i, rd_i, wr_i, rvalid_o, supply_low_i, year_wrap_i, alarm_hit_i;
    logic        wdog_expired_i, irq_req_i, update_busy_i, freeze_o, load_o, tune_o;
    logic        test_mode_o, seconds_match_o, irq_o, tune_wave_o;
    logic [14:0] addr_i;
    logic [7:0]  wdata_i, rdata_o, count_sec_i, count_byte_i, count_year_i, load_data_o, d;
    logic [2:0]  count_idx_o;
    int          err_count, n_compared, cyc, tg;
    rtc_flags_ctl #(.HALF_CYC(4)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i),
        .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .supply_low_i(supply_low_i), .year_wrap_i(year_wrap_i),
        .alarm_hit_i(alarm_hit_i), .wdog_expired_i(wdog_expired_i), .irq_req_i(irq_req_i),
        .update_busy_i(update_busy_i), .count_sec_i(count_sec_i),
        .count_byte_i(count_byte_i), .count_idx_o(count_idx_o), .count_year_i(count_year_i),
        .freeze_o(freeze_o), .load_o(load_o), .load_data_o(load_data_o), .tune_o(tune_o),
        .test_mode_o(test_mode_o), .seconds_match_o(seconds_match_o), .irq_o(irq_o),
        .tune_wave_o(tune_wave_o));
    rtc_counter_model u_cnt (.clk_i(clk_i), .idx_i(count_idx_o), .load_i(load_o),
        .load_data_i(load_data_o), .byte_o(count_byte_i));
    always #25 clk_i = ~clk_i;
    task automatic report_and_stop;
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] v);
        @(negedge clk_i); wr_i = 1; addr_i = a; wdata_i = v;
        @(negedge clk_i); wr_i = 0;
    endtask
    // Bounded wait on rvalid_o; no answer yields unknown data
    task automatic rd(input logic [14:0] a, output logic [7:0] v);
        int n;
        n = 0;
        @(negedge clk_i); rd_i = 1; addr_i = a;
        @(negedge clk_i); rd_i = 0;
        while (rvalid_o !== 1'b1 && n < 4) begin
            @(posedge clk_i); #1; n++;
        end
        v = (rvalid_o === 1'b1) ? rdata_o : 8'hxx;
    endtask
    task automatic rchk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask
    logic [7:0] al [4] = '{8'h92, 8'h34, 8'h34, 8'h59};
    logic [7:0] sc [4] = '{8'h34, 8'h34, 8'h35, 8'h59};
    logic [3:0] mt = 4'b1101;
    logic [7:0] ex [7] = '{8'h77, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56};
    initial begin
        clk_i = 0; rstn_i = 0; rd_i = 0; wr_i = 0; addr_i = 0; wdata_i = 0; count_sec_i = 0;
        {supply_low_i, year_wrap_i, alarm_hit_i, wdog_expired_i} = 4'h0;
        irq_req_i = 0; update_busy_i = 0; count_year_i = 0; cyc = 0; tg = 0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1;
        for (int i = 0; i < 3; i++) rchk(FLAGS_CTRL_OFS + 15'(i), 8'h00);
        wr(USER_BYTE_OFS, 8'ha5);
        rchk(USER_BYTE_OFS, 8'ha5);
        rchk(15'h7ff3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ALARM_SEC_OFS, al[i]);
            count_sec_i = sc[i];
            #1 chk({7'h0, seconds_match_o}, {7'h0, mt[3-i]});
        end
        rchk(ALARM_SEC_OFS, 8'h59);
        @(negedge clk_i) {supply_low_i, year_wrap_i, alarm_hit_i, wdog_expired_i} = 4'hf;
        @(negedge clk_i) {supply_low_i, year_wrap_i, alarm_hit_i, wdog_expired_i} = 4'h0;
        wr(FLAGS_CTRL_OFS, 8'hf0);
        chk({7'h0, test_mode_o}, 8'h00);
        rchk(FLAGS_CTRL_OFS, 8'hf0);
        rchk(FLAGS_CTRL_OFS, 8'h00);
        wr(FLAGS_CTRL_OFS, 8'h02);
        chk({7'h0, freeze_o}, 8'h01);
        for (int i = 0; i < 7; i++) wr(TIME_LO_OFS + 15'(i), 8'h50 + 8'(i));
        wr(FLAGS_CTRL_OFS, 8'h00);
        repeat (12) @(negedge clk_i);
        for (int i = 0; i < 7; i++) chk(u_cnt.cnt[i], 8'h50 + 8'(i));
        update_busy_i = 1;
        wr(FLAGS_CTRL_OFS, 8'h01);
        repeat (2) @(negedge clk_i);
        // Late counter update; an early capture would miss it
        u_cnt.cnt[0] = 8'h77;
        @(negedge clk_i) update_busy_i = 0;
        repeat (12) @(negedge clk_i);
        wr(FLAGS_CTRL_OFS, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd(TIME_LO_OFS + 15'(i), d);
            chk(d, ex[i]);
        end
        wr(FLAGS_CTRL_OFS, 8'h02);
        u_cnt.cnt[0] = 8'h88;
        wr(FLAGS_CTRL_OFS, 8'h03);
        repeat (10) @(negedge clk_i);
        rchk(TIME_LO_OFS, 8'h77);
        wr(FLAGS_CTRL_OFS, 8'h00);
        repeat (12) @(negedge clk_i);
        chk(u_cnt.cnt[0], 8'h77);
        wr(FLAGS_CTRL_OFS, 8'h04);
        irq_req_i = 1;
        chk({6'h0, tune_o, irq_o}, 8'h02);
        d[0] = tune_wave_o;
        repeat (20) @(negedge clk_i) begin
            if (tune_wave_o !== d[0]) tg++;
            d[0] = tune_wave_o;
        end
        chk(8'(tg == 5), 8'h01);
        wr(FLAGS_CTRL_OFS, 8'h00);
        chk({7'h0, irq_o}, 8'h01);
        report_and_stop;
    end
endmodule
